// ==== hw/event_timestamp_sample_regs.sv ====
// Fourth and fifth event timestamp sample registers behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
module event_timestamp_sample_regs #(
  parameter int ADDR_W = 12,
  parameter int NUM_UNITS = 2
) (
  input wire logic sys_clk,
  input wire logic srst,
  // APB slave.
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture strobe from the timestamp capture logic on this clock.
  input wire logic capture_valid,
  input wire logic capture_unit,
  input wire logic capture_sample,
  input wire logic capture_rising,
  input wire logic [29:0] capture_ns,
  input wire logic [31:0] capture_sec,
  input wire logic [2:0] capture_slot,
  // Unit currently selected for reading.
  output logic unit_pointer
);
  import sample_regs_pkg::*;

  localparam int DEPTH = NUM_UNITS * 2;
  localparam int STORE_AW = $clog2(DEPTH);

  typedef struct packed {
    apb_state_t st;
    logic unit_ptr;
    logic sample_sel;
    logic [1:0] word_sel;
    logic err;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  logic [MEM_DATA_W-1:0] cap_word;
  logic [MEM_DATA_W-1:0] rd_word;
  logic [STORE_AW-1:0] wr_addr;
  logic [STORE_AW-1:0] rd_addr;
  logic dec_sample;
  logic [1:0] dec_word;
  logic dec_err;
  logic [ADDR_W-1:0] addr_lo;

  // One stored word per unit and sample keeps the fourth and fifth sets
  // apart; both sets share storage but never a slot.
  always_comb begin
    cap_word = '0;
    cap_word[MEM_EDGE_BIT] = capture_rising;
    cap_word[MEM_NS_LSB +: 30] = capture_ns;
    cap_word[MEM_SEC_LSB +: 32] = capture_sec;
    cap_word[MEM_PHASE_LSB +: 3] = phase_code(capture_slot);
    wr_addr = STORE_AW'({capture_unit, capture_sample});
  end

  // The pointer picks the unit; the address picks fourth or fifth sample.
  assign rd_addr = STORE_AW'({r_q.unit_ptr, dec_sample});

  sample_store #(
    .DATA_W(MEM_DATA_W),
    .DEPTH(DEPTH),
    .ADDR_W(STORE_AW)
  ) u_store (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(capture_valid),
    .wr_addr(wr_addr),
    .wr_data(cap_word),
    .rd_addr(rd_addr),
    .rd_data(rd_word)
  );

  // Address decode of the setup phase; anything else answers with an error.
  always_comb begin
    addr_lo = paddr;
    dec_sample = 1'b0;
    dec_word = WORD_INDEX;
    dec_err = 1'b0;
    if (addr_lo == ADDR_W'(SAMPLE4_NANOSECONDS_OFF)) begin
      dec_word = WORD_NS;
    end else if (addr_lo == ADDR_W'(SAMPLE4_SECONDS_OFF)) begin
      dec_word = WORD_SEC;
    end else if (addr_lo == ADDR_W'(SAMPLE4_PHASE_OFF)) begin
      dec_word = WORD_PHASE;
    end else if (addr_lo == ADDR_W'(SAMPLE5_NANOSECONDS_OFF)) begin
      dec_sample = 1'b1;
      dec_word = WORD_NS;
    end else if (addr_lo == ADDR_W'(SAMPLE5_SECONDS_OFF)) begin
      dec_sample = 1'b1;
      dec_word = WORD_SEC;
    end else if (addr_lo == ADDR_W'(SAMPLE5_PHASE_OFF)) begin
      dec_sample = 1'b1;
      dec_word = WORD_PHASE;
    end else if (addr_lo == ADDR_W'(UNIT_INDEX_OFF)) begin
      dec_word = WORD_INDEX;
    end else begin
      dec_err = 1'b1;
    end
  end

  // Every access takes the same path: setup issues the store read, the
  // first access cycle assembles the word, the second raises pready. The
  // fixed latency costs a cycle on the index register but keeps the
  // sequencer trivial.
  always_comb begin
    r_d = r_q;
    r_d.pready = 1'b0;
    case (r_q.st)
      ST_IDLE: begin
        r_d.pslverr = 1'b0;
        if (psel && !penable) begin
          r_d.sample_sel = dec_sample;
          r_d.word_sel = dec_word;
          r_d.err = dec_err;
          r_d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        r_d.prdata = REG_RESET;
        if (r_q.err) begin
          r_d.pslverr = 1'b1;
        end else if (r_q.word_sel == WORD_NS) begin
          r_d.prdata[EDGE_BIT] = rd_word[MEM_EDGE_BIT];
          r_d.prdata[NS_MSB:0] = rd_word[MEM_NS_LSB +: 30];
        end else if (r_q.word_sel == WORD_SEC) begin
          r_d.prdata = rd_word[MEM_SEC_LSB +: 32];
        end else if (r_q.word_sel == WORD_PHASE) begin
          r_d.prdata[PHASE_MSB:0] = rd_word[MEM_PHASE_LSB +: 3];
        end else begin
          r_d.prdata[UNIT_PTR_BIT] = r_q.unit_ptr;
        end
        r_d.pready = 1'b1;
        r_d.st = ST_REPLY;
      end
      ST_REPLY: begin
        // The write lands on the very edge at which pready is sampled.
        if (psel && penable && pwrite && !r_q.err && pstrb[1] &&
            r_q.word_sel == WORD_INDEX) begin
          r_d.unit_ptr = pwdata[UNIT_PTR_BIT];
        end
        r_d.prdata = REG_RESET;
        r_d.pslverr = 1'b0;
        r_d.st = ST_IDLE;
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  // Reset returns the sequencer to idle and every output to zero.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_q <= '{st: ST_IDLE, unit_ptr: UNIT_PTR_RESET, sample_sel: 1'b0,
               word_sel: WORD_NS, err: 1'b0, prdata: REG_RESET,
               pready: 1'b0, pslverr: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign unit_pointer = r_q.unit_ptr;

endmodule
`default_nettype wire

// ==== hw/sample_regs_pkg.sv ====
// Constants, types and helpers shared by the timestamp sample register block.
// Overview of operation
// - Edge flag bit 30 reads 1 for a rising input edge, 0 for falling.
// - Fourth sample nanoseconds read back as a 30-bit field in bits 29:0.
// - Sample seconds read back as a full 32-bit value in bits 31:0.
// - A 3-bit phase field, bits 2:0, names the 8 ns slot in 40 ns.
// - Phase codes 000, 001, 010, 011, 100 for 0, 8, 16, 24, 32 ns; 101-111 never.
// - Registers show the unit named by pointer bit 8; software sets it first.
// - Fifth sample keeps its own edge, nanoseconds, seconds and phase fields.
package sample_regs_pkg;

  // Byte offsets of the sample registers.
  localparam logic [11:0] SAMPLE4_NANOSECONDS_OFF = 12'h578;
  localparam logic [11:0] SAMPLE4_SECONDS_OFF = 12'h57c;
  localparam logic [11:0] SAMPLE4_PHASE_OFF = 12'h580;
  localparam logic [11:0] SAMPLE5_NANOSECONDS_OFF = 12'h584;
  localparam logic [11:0] SAMPLE5_SECONDS_OFF = 12'h588;
  localparam logic [11:0] SAMPLE5_PHASE_OFF = 12'h58c;
  // Unit index register holding the unit pointer.
  localparam logic [11:0] UNIT_INDEX_OFF = 12'h500;

  // Field positions inside the 32-bit registers.
  localparam int EDGE_BIT = 30;
  localparam int NS_MSB = 29;
  localparam int PHASE_MSB = 2;
  localparam int UNIT_PTR_BIT = 8;

  // Field positions inside one stored sample word.
  localparam int MEM_PHASE_LSB = 0;
  localparam int MEM_SEC_LSB = 3;
  localparam int MEM_NS_LSB = 35;
  localparam int MEM_EDGE_BIT = 65;
  localparam int MEM_DATA_W = 66;

  // Values after reset.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic UNIT_PTR_RESET = 1'b0;

  // Which word of a sample set an access addresses.
  localparam logic [1:0] WORD_NS = 2'h0;
  localparam logic [1:0] WORD_SEC = 2'h1;
  localparam logic [1:0] WORD_PHASE = 2'h2;
  localparam logic [1:0] WORD_INDEX = 2'h3;

  // Phase codes for the five 8 ns slots of one base clock period.
  localparam logic [2:0] PHASE_0NS = 3'h0;
  localparam logic [2:0] PHASE_8NS = 3'h1;
  localparam logic [2:0] PHASE_16NS = 3'h2;
  localparam logic [2:0] PHASE_24NS = 3'h3;
  localparam logic [2:0] PHASE_32NS = 3'h4;

  // Bus answer sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_REPLY = 3'b100
  } apb_state_t;

  // Map a slot index 0..4 onto its phase code; out of range saturates.
  function automatic logic [2:0] phase_code(input logic [2:0] slot);
    logic [2:0] code;
    code = PHASE_32NS;
    case (slot)
      3'h0: code = PHASE_0NS;
      3'h1: code = PHASE_8NS;
      3'h2: code = PHASE_16NS;
      3'h3: code = PHASE_24NS;
      default: code = PHASE_32NS;
    endcase
    return code;
  endfunction

endpackage

// ==== hw/sample_store.sv ====
// Small sample store with a registered read port and a reset clear.
`timescale 1ns/1ps
`default_nettype none
module sample_store #(
  parameter int DATA_W = 66,
  parameter int DEPTH = 4,
  parameter int ADDR_W = 2
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rd_data;
  } store_t;

  store_t r_q;
  store_t r_d;

  // Read data always comes from a register, so a same-cycle write is seen
  // one cycle later, never through a combinational path.
  always_comb begin
    r_d = r_q;
    r_d.rd_data = r_q.mem[rd_addr];
    if (wr_en) begin
      r_d.mem[wr_addr] = wr_data;
    end
  end

  // Reset clears every entry so all fields read zero until captured.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign rd_data = r_q.rd_data;

endmodule
`default_nettype wire

// ==== sim/event_timestamp_sample_regs_chk.sv ====
// Port-level assertions for the timestamp sample register block.
`timescale 1ns/1ps
`default_nettype none
module event_timestamp_sample_regs_chk
  import sample_regs_pkg::*;
#(parameter int ADDR_W = 12) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_pointer
);
  import sample_regs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Decoded answer kinds; the pointer write needs its byte lane enabled.
  logic rd_ns, rd_ph, wr_ix;
  assign rd_ns = pready && !pwrite && (paddr == SAMPLE4_NANOSECONDS_OFF ||
                 paddr == SAMPLE5_NANOSECONDS_OFF);
  assign rd_ph = pready && !pwrite && (paddr == SAMPLE4_PHASE_OFF ||
                 paddr == SAMPLE5_PHASE_OFF);
  assign wr_ix = pready && pwrite && paddr == UNIT_INDEX_OFF;
  property p_ans; psel && !penable |-> ##2 pready; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; pslverr |-> pready && prdata == '0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_zero; !pready |-> prdata == '0 && !pslverr; endproperty
  a_zero: assert property (p_zero) else $error("idle data");
  property p_ns; rd_ns |-> !prdata[31] && !pslverr; endproperty
  a_ns: assert property (p_ns) else $error("ns top bit");
  property p_phase; rd_ph |-> prdata[31:3] == '0 && prdata[2:0] <= 3'h4;
  endproperty
  a_phase: assert property (p_phase) else $error("phase code");
  property p_ptr; wr_ix && pstrb[1] |=> unit_pointer == $past(pwdata[8]);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write");
  property p_hold; !wr_ix |=> $stable(unit_pointer); endproperty
  a_hold: assert property (p_hold) else $error("pointer moved");
  // A pointer write with its byte lane off must leave the pointer alone.
  property p_lane; wr_ix && !pstrb[1] |=> $stable(unit_pointer);
  endproperty
  a_lane: assert property (p_lane) else $error("pointer lane");
endmodule
bind event_timestamp_sample_regs event_timestamp_sample_regs_chk
  #(.ADDR_W(ADDR_W)) i_chk (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .unit_pointer(unit_pointer));
`default_nettype wire

// ==== sim/event_timestamp_sample_regs_tb_top.sv ====
// Self-checking bench for the timestamp sample register block.
`timescale 1ns/1ps
`default_nettype none
module event_timestamp_sample_regs_tb_top;
  import sample_regs_pkg::*;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic cv = 0, cu = 0, cs = 0, cr = 0, pready, pslverr, unit_pointer;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, cx = '0, prdata, rd;
  logic [29:0] cn = '0;
  logic [2:0] cl = '0;
  logic [3:0] ps = 4'hf;
  int fail_count = 0, cmp_count = 0;
  // Free-running base clock, 40 ns period.
  always #20 sys_clk = ~sys_clk;
  event_timestamp_sample_regs i_dut (.sys_clk(sys_clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(ps), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_valid(cv), .capture_unit(cu),
    .capture_sample(cs), .capture_rising(cr), .capture_ns(cn),
    .capture_sec(cx), .capture_slot(cl), .unit_pointer(unit_pointer));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check({er, rd}, {1'b0, exp});
  endtask
  // One-cycle capture strobe carrying a whole sample.
  task automatic cap(input logic u, input logic s, input logic r,
                     input logic [29:0] n, input logic [31:0] x,
                     input logic [2:0] l);
    cv <= 1'b1;
    cu <= u;
    cs <= s;
    cr <= r;
    cn <= n;
    cx <= x;
    cl <= l;
    @(posedge sys_clk);
    cv <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rdchk(12'h578 + 12'(4 * i), '0);
    rdchk(UNIT_INDEX_OFF, '0);
  endtask
  // Every slot, alternating edges, then a fifth sample beside it.
  task automatic t_slots();
    logic [2:0] code[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    for (int i = 0; i < 5; i++) begin
      cap(1'b0, 1'b0, i[0], 30'h2aaa_aaa0 | 30'(i), 32'hffff_0000 | i, 3'(i));
      rdchk(SAMPLE4_NANOSECONDS_OFF,
            {1'b0, i[0], 30'h2aaa_aaa0 | 30'(i)});
      rdchk(SAMPLE4_SECONDS_OFF, 32'hffff_0000 | i);
      rdchk(SAMPLE4_PHASE_OFF, {29'h0, code[i]});
    end
    cap(1'b0, 1'b1, 1'b1, 30'h1234_5678, 32'h8765_4321, 3'h2);
    rdchk(SAMPLE5_NANOSECONDS_OFF, 32'h5234_5678);
    rdchk(SAMPLE5_SECONDS_OFF, 32'h8765_4321);
    rdchk(SAMPLE5_PHASE_OFF, 32'h0000_0002);
    rdchk(SAMPLE4_NANOSECONDS_OFF, 32'h2aaa_aaa4);
  endtask
  // Unit switching, a refused write and an unmapped address.
  task automatic t_unit();
    apb(1'b1, UNIT_INDEX_OFF, 32'h0000_0100);
    check(unit_pointer, 1'b1);
    rdchk(UNIT_INDEX_OFF, 32'h0000_0100);
    rdchk(SAMPLE4_NANOSECONDS_OFF, '0);
    cap(1'b1, 1'b0, 1'b1, 30'h0000_0011, 32'h0000_0022, 3'h3);
    rdchk(SAMPLE4_NANOSECONDS_OFF, 32'h4000_0011);
    rdchk(SAMPLE4_PHASE_OFF, 32'h0000_0003);
    apb(1'b1, UNIT_INDEX_OFF, '0);
    // With the pointer's byte lane off the write must not move it.
    ps <= 4'h1;
    apb(1'b1, UNIT_INDEX_OFF, 32'h0000_0100);
    check(unit_pointer, 1'b0);
    ps <= 4'hf;
    rdchk(SAMPLE4_SECONDS_OFF, 32'hffff_0004);
    apb(1'b1, SAMPLE4_SECONDS_OFF, 32'hdead_beef);
    check(er, 1'b0);
    rdchk(SAMPLE4_SECONDS_OFF, 32'hffff_0004);
    apb(1'b0, 12'h590, '0);
    check({er, rd}, {1'b1, 32'h0});
  endtask
  // A reset in mid-run must clear the pointer and the unit 0 fifth nanoseconds and fourth seconds read back.
  task automatic t_midrst();
    apb(1'b1, UNIT_INDEX_OFF, 32'h0000_0100);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check(unit_pointer, 1'b0);
    rdchk(SAMPLE5_NANOSECONDS_OFF, '0);
    rdchk(SAMPLE4_SECONDS_OFF, '0);
  endtask
  // Hold reset for 20 cycles, then run each scenario in turn.
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_slots();
    t_unit();
    t_midrst();
    end_sim();
  end
endmodule
`default_nettype wire
